// ==== logic/edp_dio_top.sv ====
`timescale 1ns/1ps
`include "edp_defs.svh"
module edp_dio_top
  import edp_pkg::*;
#(
  parameter int NPORT = `EDP_NPORT,
  parameter int NEDGE = `EDP_NEDGE
) (
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [`EDP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EDP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [8*NPORT-1:0] pin_in,
  output logic [8*NPORT-1:0] pin_out,
  output logic [8*NPORT-1:0] pin_oe,
  // interrupts
  output logic irq,
  output logic board_req
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic edp_mapped(
    input logic [`EDP_ADDR_W-1:0] a
  );
    logic ok;
    ok = (a[1:0] == 2'b00) && (a <= `EDP_OFS_MASK);
    return ok;
  endfunction : edp_mapped

  function automatic edp_word_t edp_merge(
    input edp_word_t old,
    input edp_word_t nw,
    input edp_strb_t strb
  );
    edp_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8+:8] = nw[b*8+:8];
      end
    end
    return r;
  endfunction : edp_merge

  function automatic logic edp_is_out(
    input logic [`EDP_ADDR_W-1:0] a,
    input int n
  );
    logic hitn;
    hitn = (a == `EDP_OFS_OUT_BASE + 8'(4 * n));
    return hitn;
  endfunction : edp_is_out

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  edp_byte_t out_q [NPORT];
  logic [NPORT-1:0] freeze_q;
  logic [NPORT-1:0] dir_q;
  logic [8*NEDGE-1:0] pol_q;
  logic [NEDGE-1:0] det_en_q;
  logic [NEDGE-1:0] stat_q;
  logic [NEDGE-1:0] mask_q;
  logic [8*NPORT-1:0] pins_s;
  logic [NEDGE-1:0] clr_pulse;
  logic int_rst_pulse;

  logic [`EDP_ADDR_W-1:0] awaddr_q;
  edp_word_t wdata_q;
  edp_strb_t wstrb_q;
  logic have_aw_q;
  logic have_w_q;
  logic bvalid_q;
  edp_resp_t bresp_q;
  logic wr_fire;
  edp_word_t wr_old;
  edp_word_t wr_val;

  logic rvalid_q;
  edp_word_t rdata_q;
  edp_resp_t rresp_q;
  edp_word_t rd_val;

  edp_edge_if #(.NE(NEDGE)) eif ();

  // ---------------------------------------------------------------
  // pin synchroniser and edge detectors
  // ---------------------------------------------------------------
  edp_sync #(.W(8*NPORT)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(pin_in),
    .q(pins_s)
  );

  assign eif.pins = pins_s[8*NEDGE-1:0];
  assign eif.pol = pol_q;
  assign eif.en = det_en_q;
  assign eif.clr = clr_pulse | {NEDGE{int_rst_pulse}};

  edp_edge #(.NE(NEDGE)) u_edge (
    .clk(clk),
    .resetn(resetn),
    .eif(eif)
  );

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  // each address or data beat is held until both are present
  assign s_axi_awready = !have_aw_q && !bvalid_q;
  assign s_axi_wready = !have_w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = have_aw_q && have_w_q && !bvalid_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= `EDP_RST_WORD;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `EDP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= edp_mapped(awaddr_q) ? `EDP_RESP_OKAY
                                        : `EDP_RESP_DECERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // old value of the addressed word, so strobes merge byte by byte
  always_comb begin
    wr_old = `EDP_RST_WORD;
    for (int n = 0; n < NPORT; n++) begin
      if (edp_is_out(awaddr_q, n)) begin
        wr_old = 32'(out_q[n]);
      end
    end
    case (awaddr_q)
      `EDP_OFS_FREEZE: wr_old = 32'(freeze_q);
      `EDP_OFS_DIR: wr_old = 32'(dir_q);
      `EDP_OFS_POL: wr_old = 32'(pol_q);
      `EDP_OFS_DET_EN: wr_old = 32'(det_en_q);
      `EDP_OFS_MASK: wr_old = 32'(mask_q);
      default: ;
    endcase
  end

  assign wr_val = edp_merge(wr_old, wdata_q, wstrb_q);

  // command pulses: bits read back as zero
  always_comb begin
    clr_pulse = '0;
    int_rst_pulse = 1'b0;
    if (wr_fire && awaddr_q == `EDP_OFS_FLAG_CLR) begin
      clr_pulse = wr_val[NEDGE-1:0];
    end
    if (wr_fire && awaddr_q == `EDP_OFS_INT_RST) begin
      int_rst_pulse = wr_val[`EDP_INT_RST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // output ports
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int n = 0; n < NPORT; n++) begin
        out_q[n] <= '0;
      end
    end else if (wr_fire) begin
      for (int n = 0; n < NPORT; n++) begin
        // frozen ports silently keep their value
        if (edp_is_out(awaddr_q, n) && !freeze_q[n]) begin
          out_q[n] <= wr_val[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      freeze_q <= '0;
    end else if (wr_fire && awaddr_q == `EDP_OFS_FREEZE) begin
      freeze_q <= wr_val[NPORT-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dir_q <= '0;
    end else if (wr_fire && awaddr_q == `EDP_OFS_DIR) begin
      dir_q <= wr_val[NPORT-1:0];
    end
  end

  for (genvar n = 0; n < NPORT; n++) begin : g_pin
    assign pin_out[n*8+:8] = out_q[n];
    assign pin_oe[n*8+:8] = {8{dir_q[n]}};
  end

  // ---------------------------------------------------------------
  // edge configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pol_q <= '0;
    end else if (wr_fire && awaddr_q == `EDP_OFS_POL) begin
      pol_q <= wr_val[8*NEDGE-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      det_en_q <= '0;
    end else if (wr_fire && awaddr_q == `EDP_OFS_DET_EN) begin
      det_en_q <= wr_val[NEDGE-1:0];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  // a fresh edge in the cycle of a write-one-clear keeps the bit set
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stat_q <= '0;
    end else begin
      for (int p = 0; p < NEDGE; p++) begin
        if (eif.ev[p]) begin
          stat_q[p] <= 1'b1;
        end else if (int_rst_pulse) begin
          stat_q[p] <= 1'b0;
        end else if (wr_fire && awaddr_q == `EDP_OFS_STAT &&
                     wr_val[p]) begin
          stat_q[p] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_q <= '0;
    end else if (wr_fire && awaddr_q == `EDP_OFS_MASK) begin
      mask_q <= wr_val[NEDGE-1:0];
    end
  end

  // irq follows the mask at once; board_req ignores the mask
  assign irq = |(stat_q & mask_q);
  assign board_req = |eif.req;

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // everything software can set reads back as written, except the command pulses, which read zero
  always_comb begin
    rd_val = `EDP_RST_WORD;
    for (int n = 0; n < NPORT; n++) begin
      if (edp_is_out(s_axi_araddr, n)) begin
        rd_val = 32'(out_q[n]);
      end
    end
    case (s_axi_araddr)
      `EDP_OFS_PIN_LO: rd_val = pins_s[31:0];
      `EDP_OFS_PIN_HI: rd_val = 32'(pins_s[8*NPORT-1:32]);
      `EDP_OFS_FREEZE: rd_val = 32'(freeze_q);
      `EDP_OFS_DIR: rd_val = 32'(dir_q);
      `EDP_OFS_POL: rd_val = 32'(pol_q);
      `EDP_OFS_DET_EN: rd_val = 32'(det_en_q);
      `EDP_OFS_FLAGS: rd_val = 32'(eif.flags);
      `EDP_OFS_IRQ_REQ: rd_val = 32'(eif.req);
      `EDP_OFS_STAT: rd_val = 32'(stat_q);
      `EDP_OFS_MASK: rd_val = 32'(mask_q);
      default: ;
    endcase
  end

  // unmapped reads answer zero so no stale word leaks out
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= `EDP_RST_WORD;
      rresp_q <= `EDP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      if (edp_mapped(s_axi_araddr)) begin
        rdata_q <= rd_val;
        rresp_q <= `EDP_RESP_OKAY;
      end else begin
        rdata_q <= `EDP_RST_WORD;
        rresp_q <= `EDP_RESP_DECERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : edp_dio_top

// ==== logic/edp_defs.svh ====
`ifndef EDP_DEFS_SVH
`define EDP_DEFS_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define EDP_ADDR_W 8
`define EDP_NPORT 6
`define EDP_NEDGE 3
`define EDP_PORT_W 8

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EDP_OFS_OUT_BASE 8'h00
`define EDP_OFS_PIN_LO 8'h18
`define EDP_OFS_PIN_HI 8'h1C
`define EDP_OFS_FREEZE 8'h20
`define EDP_OFS_DIR 8'h24
`define EDP_OFS_POL 8'h28
`define EDP_OFS_DET_EN 8'h2C
`define EDP_OFS_FLAG_CLR 8'h30
`define EDP_OFS_FLAGS 8'h34
`define EDP_OFS_IRQ_REQ 8'h38
`define EDP_OFS_INT_RST 8'h3C
`define EDP_OFS_STAT 8'h40
`define EDP_OFS_MASK 8'h44

// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define EDP_RST_WORD 32'h0000_0000
`define EDP_RESP_OKAY 2'h0
`define EDP_RESP_DECERR 2'h3
`define EDP_INT_RST_BIT 0
`endif

// ==== logic/edp_pkg.sv ====
package edp_pkg;
  typedef logic [7:0] edp_byte_t;
  typedef logic [31:0] edp_word_t;
  typedef logic [1:0] edp_resp_t;
  typedef logic [3:0] edp_strb_t;
endpackage : edp_pkg

// ==== logic/edp_edge_if.sv ====
`timescale 1ns/1ps
interface edp_edge_if #(
  parameter int NE = 3
);
  logic [8*NE-1:0] pins;
  logic [8*NE-1:0] pol;
  logic [NE-1:0] en;
  logic [NE-1:0] clr;
  logic [8*NE-1:0] flags;
  logic [NE-1:0] req;
  logic [NE-1:0] ev;
  modport det (input pins, input pol, input en, input clr,
    output flags, output req, output ev);
  modport ctl (output pins, output pol, output en, output clr,
    input flags, input req, input ev);
endinterface : edp_edge_if

// ==== logic/edp_sync.sv ====
`timescale 1ns/1ps
module edp_sync #(
  parameter int W = 48
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : edp_sync

// ==== logic/edp_edge.sv ====
`timescale 1ns/1ps
module edp_edge #(
  parameter int NE = 3
) (
  input wire logic clk,
  input wire logic resetn,
  edp_edge_if.det eif
);
  logic [8*NE-1:0] prev_q;
  logic [8*NE-1:0] hit;
  logic armed_q;

  // first sample after reset has no valid history, so no edge then
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prev_q <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q <= eif.pins;
      armed_q <= 1'b1;
    end
  end

  for (genvar p = 0; p < NE; p++) begin : g_port
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flag_q;
    assign rise = eif.pins[p*8+:8] & ~prev_q[p*8+:8];
    assign fall = ~eif.pins[p*8+:8] & prev_q[p*8+:8];
    assign hit[p*8+:8] = {8{eif.en[p] & armed_q}} &
      ((eif.pol[p*8+:8] & rise) | (~eif.pol[p*8+:8] & fall));

    // a new edge in the clearing cycle survives the clear
    always_ff @(posedge clk) begin
      if (!resetn) begin
        flag_q <= '0;
      end else if (eif.clr[p]) begin
        flag_q <= hit[p*8+:8];
      end else begin
        flag_q <= flag_q | hit[p*8+:8];
      end
    end

    assign eif.req[p] = |flag_q;
    assign eif.ev[p] = |hit[p*8+:8];
    assign eif.flags[p*8+:8] = flag_q;
  end
endmodule : edp_edge

// ==== tb/edp_dio_monitor.sv ====
`timescale 1ns/1ps
`include "edp_defs.svh"
module edp_dio_monitor
  import edp_pkg::*;
#(
  parameter int NPORT = 6,
  parameter int NEDGE = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [8*NPORT-1:0] pin_out,
  input wire logic [8*NPORT-1:0] pin_oe,
  input wire logic irq,
  input wire logic board_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // bus steps
  // ---------------------------------------------------------------
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_resp_a: assert property (
    wr_taken_s |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  read_resp_a: assert property (rd_taken_s |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  busy_refuse_a: assert property ((s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
    else $error("request taken while answer pending");
  // ---------------------------------------------------------------
  // pins and events
  // ---------------------------------------------------------------
  out_cause_a: assert property (!$stable({pin_out, pin_oe}) |->
    $rose(s_axi_bvalid))
    else $error("pin output moved without a write");
  flag_sticky_a: assert property (
    $fell(board_req) |-> $rose(s_axi_bvalid))
    else $error("edge flags cleared without a write");
  irq_cause_a: assert property ($rose(irq) |-> board_req ||
    $rose(s_axi_bvalid))
    else $error("interrupt without cause");
endmodule : edp_dio_monitor

bind edp_dio_top edp_dio_monitor #(.NPORT(NPORT), .NEDGE(NEDGE)) u_mon (
  .clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pin_out, .pin_oe, .irq, .board_req);

// ==== tb/edp_pin_env.sv ====
`timescale 1ns/1ps
module edp_pin_env #(
  parameter int W = 48
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_drive,
  output logic [W-1:0] pin_in
);
  // a driven pin reads back its own level; otherwise the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule : edp_pin_env

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "edp_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import edp_pkg::*;
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq, board_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, ew;
  logic [47:0] pin_in, pin_out, pin_oe, ext_drive, eo;
  logic [33:0] er;
  logic [1:0] qw[$];
  logic [33:0] qr[$];
  logic [23:0] ef;
  edp_word_t r, v;
  int fail_count, n_tests;
  edp_dio_top dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
    .pin_oe, .irq, .board_req);
  edp_pin_env env (.pin_out, .pin_oe, .ext_drive, .pin_in);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // bus master; the leading edge keeps one assignment per time step
  // ---------------------------------------------------------------
  // ready for the answer comes after a random lag so that held
  // responses are seen as well
  task automatic wr(input logic [7:0] a, input edp_word_t d,
      input logic [1:0] e);
    int lag;
    logic aw_ok, w_ok;
    lag = $urandom % 3;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    qw.push_back(e);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    repeat (lag) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int lag;
    lag = $urandom % 3;
    qr.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (lag) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // ---------------------------------------------------------------
  // scoreboard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      ew = qw.pop_front();
      `CHK(s_axi_bresp, ew)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = qr.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, er)
    end
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, ext_drive} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(57));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a <= 'h44; a += 4) rd(8'(a), 34'h0);
    rd(8'h48, {2'h3, 32'h0});
    wr(8'h4C, 32'h1, 2'h3);
    wr(`EDP_OFS_DIR, 32'h3F, 2'h0);
    `CHK(pin_oe, {48{1'b1}})
    for (int p = 0; p < 6; p++) begin
      v = $urandom;
      eo[8*p+:8] = v[7:0];
      wr(8'(4*p), v, 2'h0);
      rd(8'(4*p), {26'h0, v[7:0]});
    end
    rd(`EDP_OFS_PIN_LO, {2'h0, eo[31:0]});
    rd(`EDP_OFS_PIN_HI, {18'h0, eo[47:32]});
    `CHK(pin_out, eo)
    // frozen port keeps its value, its neighbour does not
    wr(`EDP_OFS_FREEZE, 32'h05, 2'h0);
    rd(`EDP_OFS_FREEZE, 34'h05);
    wr(8'h00, ~eo[31:0], 2'h0);
    wr(8'h04, 32'h5A, 2'h0);
    rd(8'h00, {26'h0, eo[7:0]});
    rd(8'h04, 34'h5A);
    wr(`EDP_OFS_FREEZE, 32'h0, 2'h0);
    wr(`EDP_OFS_DIR, 32'h0, 2'h0);
    `CHK(pin_oe, 48'h0)
    r = $urandom;
    ext_drive <= {16'h0, r};
    wr(`EDP_OFS_POL, 32'h00FF00, 2'h0);
    wr(`EDP_OFS_DET_EN, 32'h3, 2'h0);
    ext_drive <= {16'hFFFF, ~r};
    repeat (4) @(posedge clk);
    ef = {8'h0, ~r[15:8], r[7:0]};
    rd(`EDP_OFS_FLAGS, {10'h0, ef});
    rd(`EDP_OFS_IRQ_REQ, {32'h0, |ef[15:8], |ef[7:0]});
    `CHK(board_req, |ef)
    wr(`EDP_OFS_MASK, 32'h2, 2'h0);
    `CHK(irq, |ef[15:8])
    wr(`EDP_OFS_FLAG_CLR, 32'h1, 2'h0);
    rd(`EDP_OFS_FLAGS, {10'h0, ef[23:8], 8'h0});
    rd(`EDP_OFS_STAT, {32'h0, |ef[15:8], |ef[7:0]});
    // write-one-clear of the masked port drops the interrupt line
    wr(`EDP_OFS_STAT, 32'h2, 2'h0);
    rd(`EDP_OFS_STAT, {33'h0, |ef[7:0]});
    `CHK(irq, 1'b0)
    wr(`EDP_OFS_INT_RST, 32'h1, 2'h0);
    rd(`EDP_OFS_FLAGS, 34'h0);
    rd(`EDP_OFS_STAT, 34'h0);
    `CHK({board_req, irq}, 2'h0)
    give_verdict();
  end
endmodule : tb_top
